// *** src/pulse_gen_pkg.sv ***
// Constants and types of the programmable pulse generator.
// Assumes a 32-bit classic Wishbone register bus, word aligned.
package pulse_gen_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] period_off = 8'h04;
  localparam logic [7:0] toggle_off = 8'h08;
  localparam logic [7:0] count_off = 8'h0C;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] clear_off = 8'h14;
  localparam logic [7:0] enable_off = 8'h18;
  localparam logic [7:0] prescale_off = 8'h1C;

  // ==========================================================
  // Control register fields
  localparam int init_bit = 7;
  localparam int oneshot_bit = 6;
  localparam int start_hi = 5;
  localparam int start_lo = 4;
  localparam int mode_hi = 2;
  localparam int mode_lo = 0;
  localparam int ctrl_width = 8;

  // Start select codes
  localparam logic [1:0] start_stop = 2'h0;
  localparam logic [1:0] start_command = 2'h1;
  localparam logic [1:0] start_rise = 2'h2;
  localparam logic [1:0] start_fall = 2'h3;

  // Mode select codes
  localparam logic [2:0] mode_timer = 3'h0;
  localparam logic [2:0] mode_pulse = 3'h7;

  // ==========================================================
  // Interrupt status bits
  localparam int irq_toggle_bit = 0;
  localparam int irq_period_bit = 1;
  localparam int irq_width = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] compare_reset = 16'hFFFF;
  localparam logic [15:0] prescale_reset = 16'h0000;
  localparam logic [1:0] irq_reset = 2'h0;

  // Counter run state
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_armed = 2'b01,
    st_run = 2'b10
  } run_e;

endpackage

// *** src/edge_sync.sv ***
// Two-stage synchroniser with edge detection for the trigger pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module edge_sync
  import pulse_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and edge pulses
  input wire logic pin,
  output logic rise,
  output logic fall
);

  // ==========================================================
  // Synchroniser and edge history
  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  always_comb begin
    next_meta = pin;
    next_stable = meta;
    next_last = stable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // Pin idles high; reset there so no false edge follows
      meta <= 1'b1;
      stable <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      last <= next_last;
    end
  end

  // Only the second stage feeds the detector
  assign rise = stable & ~last;
  assign fall = ~stable & last;

endmodule

// *** src/source_divider.sv ***
// Divider giving the counter's source clock as an enable pulse.
// Tick every divisor+1 cycles; divisor 0 ticks every cycle.
`timescale 1ns/1ns
module source_divider
  import pulse_gen_pkg::*;
#(
  parameter int width = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and tick
  input wire logic [width-1:0] divisor,
  output logic tick
);

  // ==========================================================
  // Down counter
  logic [width-1:0] cnt;
  logic [width-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt = cnt - {{(width-1){1'b0}}, 1'b1};
    if (cnt == '0) begin
      next_tick = 1'b1;
      next_cnt = divisor;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// *** src/pulse_gen.sv ***
// Programmable pulse generator: 16-bit up counter, two compares.
// Assumes classic Wishbone, 32-bit data, one clock, sync reset.
//
// How it works
// - Start by trigger edge or command, count ticks
// - Trigger start picks rising or falling edge
// - Oneshot bit: 0 repeats, 1 single pulse
// - Toggle match: invert, interrupt, keep counting
// - Period match repeat: invert, interrupt, clear, go
// - Start field cleared: stop, output holds level
// - Oneshot period match: invert, interrupt, self stop
// - After oneshot stop output keeps its level
// - Output pin is inverse of flip-flop
// - Reset clears the output flip-flop
// - Timer mode then pulse mode reloads flip-flop
`timescale 1ns/1ns
module pulse_gen
  import pulse_gen_pkg::*;
#(
  parameter int count_width = 16,
  parameter int prescale_width = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins
  input wire logic trigger_input,
  output logic pulse_out_n,
  // Interrupt
  output logic compare_irq
);

  // ==========================================================
  // Byte-lane merge for register writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = data[7:0];
    end
    if (sel[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // ==========================================================
  // Control field decode, used by the core logic
  function automatic logic [1:0] start_of(input logic [ctrl_width-1:0] c);
    return c[start_hi:start_lo];
  endfunction

  function automatic logic mode_is_pulse(input logic [ctrl_width-1:0] c);
    return c[mode_hi:mode_lo] == mode_pulse;
  endfunction

  // Match on the value after increment, so the pin moves with the count
  function automatic logic compare_hit(input logic [count_width-1:0] value,
                                       input logic [count_width-1:0] target);
    return value == target;
  endfunction

  // ==========================================================
  // Helpers
  logic tick;
  logic trig_rise;
  logic trig_fall;
  logic [prescale_width-1:0] prescale;

  // Divider runs free, so the first tick after a start can come early
  source_divider #(
    .width(prescale_width)
  ) u_divider (
    .clk(clk),
    .rst(rst),
    .divisor(prescale),
    .tick(tick)
  );

  edge_sync u_trigger (
    .clk(clk),
    .rst(rst),
    .pin(trigger_input),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  // ==========================================================
  // Bus decode
  logic req;
  logic wr;
  logic wr_ctrl;
  logic wr_clear;

  // No wait states: ack follows the taking edge by one cycle
  // Unmapped words still ack, so a stray access cannot hang the bus
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign wr_ctrl = wr & (adr_i == ctrl_off) & sel_i[0];
  assign wr_clear = wr & (adr_i == clear_off) & sel_i[0];

  // ==========================================================
  // Register group: compares, enables, divider, bus answer
  // Limitation: a compare moved below a running count waits for the wrap
  logic [count_width-1:0] period_compare;
  logic [count_width-1:0] toggle_compare;
  logic [irq_width-1:0] irq_enable;
  logic [count_width-1:0] next_period;
  logic [count_width-1:0] next_toggle;
  logic [irq_width-1:0] next_enable;
  logic [prescale_width-1:0] next_prescale;
  logic next_ack;
  logic [31:0] next_dat;

  // Core state, declared here for readback
  logic [ctrl_width-1:0] ctrl;
  logic [count_width-1:0] count;
  logic [irq_width-1:0] irq_status;
  logic out_ff;
  run_e state;

  always_comb begin
    next_period = period_compare;
    next_toggle = toggle_compare;
    next_enable = irq_enable;
    next_prescale = prescale;
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (wr) begin
      case (adr_i)
        period_off: begin
          next_period = merge16(period_compare, dat_i, sel_i);
        end
        toggle_off: begin
          next_toggle = merge16(toggle_compare, dat_i, sel_i);
        end
        enable_off: begin
          if (sel_i[0]) begin
            next_enable = dat_i[irq_width-1:0];
          end
        end
        prescale_off: begin
          next_prescale = merge16(prescale, dat_i, sel_i);
        end
        default: begin
        end
      endcase
    end
    if (req & ~we_i) begin
      case (adr_i)
        ctrl_off: next_dat = {24'h00_0000, ctrl};
        period_off: next_dat = {16'h0000, period_compare};
        toggle_off: next_dat = {16'h0000, toggle_compare};
        count_off: next_dat = {16'h0000, count};
        status_off: next_dat = {30'h0, irq_status};
        enable_off: next_dat = {30'h0, irq_enable};
        prescale_off: next_dat = {16'h0000, prescale};
        // Clear register and unmapped words read as zero
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_compare <= compare_reset;
      toggle_compare <= compare_reset;
      irq_enable <= irq_reset;
      prescale <= prescale_reset;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      period_compare <= next_period;
      toggle_compare <= next_toggle;
      irq_enable <= next_enable;
      prescale <= next_prescale;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ==========================================================
  // Core group: control, counter, flip-flop, interrupts
  logic [ctrl_width-1:0] next_ctrl;
  logic [count_width-1:0] next_count;
  logic [count_width-1:0] inc;
  logic [irq_width-1:0] next_status;
  logic [irq_width-1:0] events;
  logic next_ff;
  logic next_irq;
  logic trig_hit;
  logic pulse_mode;
  run_e next_state;

  assign pulse_mode = mode_is_pulse(ctrl);
  assign inc = count + {{(count_width-1){1'b0}}, 1'b1};
  // Edge choice follows the start field
  assign trig_hit = (start_of(ctrl) == start_rise) ? trig_rise
                                                   : trig_fall;

  always_comb begin
    next_ctrl = ctrl;
    next_count = count;
    next_ff = out_ff;
    next_state = state;
    events = '0;
    if (wr_ctrl) begin
      next_ctrl = dat_i[ctrl_width-1:0];
      // Entering pulse mode from another mode reloads the flip-flop
      if (mode_is_pulse(dat_i[ctrl_width-1:0]) && !pulse_mode) begin
        next_ff = dat_i[init_bit];
      end
    end
    case (state)
      st_idle: begin
        // Counter clears on each start from idle, not on the stop
        if (pulse_mode && start_of(ctrl) != start_stop) begin
          next_count = '0;
          if (start_of(ctrl) == start_command) begin
            next_state = st_run;
          end else begin
            next_state = st_armed;
          end
        end
      end
      st_armed: begin
        if (trig_hit) begin
          next_state = st_run;
        end
      end
      st_run: begin
        // Compare checked on each source-clock increment
        if (tick) begin
          next_count = inc;
          if (compare_hit(inc, toggle_compare)) begin
            next_ff = ~next_ff;
            events[irq_toggle_bit] = 1'b1;
          end
          if (compare_hit(inc, period_compare)) begin
            next_ff = ~next_ff;
            events[irq_period_bit] = 1'b1;
            next_count = '0;
            if (ctrl[oneshot_bit]) begin
              // Oneshot stops itself; flip-flop is left as is
              next_ctrl[start_hi:start_lo] = start_stop;
              next_state = st_idle;
            end
          end
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // Stop: counter kept, flip-flop untouched so the pin holds
    if (start_of(next_ctrl) == start_stop
        || !mode_is_pulse(next_ctrl)) begin
      next_state = st_idle;
    end
    // Hardware set wins over a same-cycle software clear
    next_status = irq_status;
    if (wr_clear) begin
      next_status = irq_status & ~dat_i[irq_width-1:0];
    end
    next_status = next_status | events;
    next_irq = |(next_status & irq_enable);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= ctrl_reset;
      count <= '0;
      out_ff <= 1'b0;
      pulse_out_n <= 1'b1;
      state <= st_idle;
      irq_status <= irq_reset;
      compare_irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      count <= next_count;
      out_ff <= next_ff;
      pulse_out_n <= ~next_ff;
      state <= next_state;
      irq_status <= next_status;
      compare_irq <= next_irq;
    end
  end

endmodule

// *** tb/pulse_gen_checker.sv ***
// Port-level assertions for the pulse generator.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module pulse_gen_checker
  import pulse_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins
  input wire logic trigger_input,
  input wire logic pulse_out_n,
  input wire logic compare_irq
);
  // ==========================================
  // Shadow of enable and run state
  logic [1:0] en;
  logic [1:0] next_en;
  logic run;
  logic next_run;
  logic wr;
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  always_comb begin
    next_en = en;
    next_run = run;
    if (wr && adr_i == enable_off)
      next_en = dat_i[1:0];
    if (wr && adr_i == ctrl_off)
      next_run = dat_i[2:0] == mode_pulse && dat_i[5:4] != start_stop;
  end
  // One-shot self stop is not tracked, so run stays pessimistic
  always_ff @(posedge clk) begin
    if (rst) begin
      en <= irq_reset;
      run <= 1'b0;
    end else begin
      en <= next_en;
      run <= next_run;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  chk_idle_data: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  chk_unmapped_read: assert property (ack_o && !we_i && adr_i > prescale_off |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_pin: assert property ($fell(rst) |-> pulse_out_n && !compare_irq)
    else $error("pin or irq wrong after reset");
  chk_match_irq: assert property ($changed(pulse_out_n) && !ack_o && !$past(ack_o)
    && en == 2'h3 && $past(en) == 2'h3 |-> compare_irq) else $error("edge without irq");
  chk_irq_masked: assert property (en == 2'h0 && $past(en) == 2'h0 |-> !compare_irq)
    else $error("irq while masked");
  chk_stopped_hold: assert property (!run && !ack_o && !$past(ack_o) |-> $stable(pulse_out_n))
    else $error("pin moved while stopped");
endmodule

// *** tb/pulse_gen_partner.sv ***
// Far side: trigger source on the trigger pin, load on the pulse pin.
// Assumes the bench calls set_level to make trigger edges.
`timescale 1ns/1ns
module pulse_gen_partner (
  // Clock
  input wire logic clk,
  // Pins
  output logic trigger_input,
  input wire logic pulse_out_n
);
  int edges_seen;
  initial begin
    trigger_input = 1'b1;
    edges_seen = 0;
  end
  // Level held past the synchroniser, else the edge may be lost
  task automatic set_level(input logic lvl);
    @(posedge clk);
    trigger_input <= lvl;
    repeat (4) @(posedge clk);
  endtask
  always @(pulse_out_n) edges_seen++;
endmodule

// *** tb/pulse_gen_tb_top.sv ***
// Self-checking bench of the pulse generator, random spans.
// Assumes the partner model drives the trigger pin.
`timescale 1ns/1ns
module pulse_gen_tb_top
  import pulse_gen_pkg::*;
;
  logic clk, rst, cyc_i, stb_i, we_i, trig, pulse_out_n, compare_irq, ack_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i, lanes;
  logic [31:0] dat_i, dat_o, rd;
  int err_total, compares, n, p, t, ps, mark;
  pulse_gen pulse_gen_inst (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trigger_input(trig), .pulse_out_n(pulse_out_n), .compare_irq(compare_irq));
  pulse_gen_partner pulse_gen_partner_inst (.clk(clk), .trigger_input(trig),
    .pulse_out_n(pulse_out_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= lanes;
    @(posedge clk);
    while (ack_o !== 1'b1) @(posedge clk);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_pin(input logic lvl);
    n = 0;
    while (pulse_out_n !== lvl && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = '0;
    lanes = 4'hF;
    rst = 1'b1;
    err_total = 0;
    compares = 0;
    void'($urandom(32'hA110));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk("pin after reset", 32'h1, pulse_out_n);
    wb(1'b0, period_off, 32'h0);
    chk("period reset", 32'hFFFF, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, rd);
    lanes = 4'h2;
    wb(1'b1, period_off, 32'h0000_12AB);
    lanes = 4'hF;
    wb(1'b0, period_off, 32'h0);
    chk("period lane", 32'h12FF, rd);
    wb(1'b1, enable_off, 32'h3);
    for (int i = 0; i < 4; i++) begin
      ps = i ? $urandom_range(3) : 0;
      p = i ? $urandom_range(30, 3) : 2;
      t = i ? $urandom_range(p - 1, 1) : 1;
      wb(1'b1, ctrl_off, 32'h0);
      wb(1'b1, ctrl_off, 32'h7);
      chk("reload high", 32'h1, pulse_out_n);
      wb(1'b1, prescale_off, 32'(ps));
      wb(1'b1, period_off, 32'(p));
      wb(1'b1, toggle_off, 32'(t));
      wb(1'b1, clear_off, 32'h3);
      wb(1'b1, ctrl_off, 32'h17);
      wait_pin(1'b0);
      wait_pin(1'b1);
      chk("low span", 32'((p - t) * (ps + 1)), 32'(n));
      wait_pin(1'b0);
      chk("high span", 32'(t * (ps + 1)), 32'(n));
      wb(1'b0, status_off, 32'h0);
      chk("status", 32'h3, rd);
      wb(1'b1, ctrl_off, 32'h7);
      mark = pulse_out_n;
      repeat (3 * p * (ps + 1)) @(posedge clk);
      chk("held level", 32'(mark), pulse_out_n);
      wb(1'b1, enable_off, 32'h0);
      chk("irq masked", 32'h0, compare_irq);
      wb(1'b1, enable_off, 32'h3);
      chk("irq enabled", 32'h1, compare_irq);
      wb(1'b1, clear_off, 32'h3);
      chk("irq cleared", 32'h0, compare_irq);
    end
    wb(1'b1, ctrl_off, 32'h0);
    wb(1'b1, ctrl_off, 32'h87);
    chk("reload low", 32'h0, pulse_out_n);
    mark = pulse_gen_partner_inst.edges_seen;
    wb(1'b1, ctrl_off, 32'hD7);
    repeat (3 * p * (ps + 1) + 8) @(posedge clk);
    chk("oneshot edges", 32'h2, 32'(pulse_gen_partner_inst.edges_seen - mark));
    chk("oneshot level", 32'h0, pulse_out_n);
    wb(1'b0, ctrl_off, 32'h0);
    chk("start cleared", 32'hC7, rd);
    for (int c = 2; c < 4; c++) begin
      wb(1'b1, ctrl_off, 32'h0);
      wb(1'b1, ctrl_off, 32'h7);
      pulse_gen_partner_inst.set_level(c == 2);
      wb(1'b1, ctrl_off, 32'(c * 16 + 7));
      pulse_gen_partner_inst.set_level(c != 2);
      wb(1'b0, count_off, 32'h0);
      mark = rd;
      repeat (8) @(posedge clk);
      wb(1'b0, count_off, 32'h0);
      chk("armed count", 32'(mark), rd);
      pulse_gen_partner_inst.set_level(c == 2);
      wait_pin(1'b0);
      chk("trigger start", 32'h1, 32'(n <= t * (ps + 1) + 6));
    end
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
bind pulse_gen pulse_gen_checker pulse_gen_checker_inst (.clk(clk), .rst(rst), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .trigger_input(trigger_input), .pulse_out_n(pulse_out_n),
  .compare_irq(compare_irq));
